// ### logic/rlwc_pkg.sv
package rlwc_pkg;

  // **********************************************************
  // Register map and field layout
  // **********************************************************
  localparam logic [23:0] REG_NV_ADDR = 24'h000002;
  localparam logic [23:0] REG_V_ADDR = 24'h070002;
  localparam int LAT_POS = 4;
  localparam int LAT_W = 4;
  localparam int QUAD_POS = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Writable bits; the reserved bits 3, 2 and 0 always hold zero.
  localparam logic [7:0] CFG_WR_MASK = 8'hF2;

  // **********************************************************
  // Command opcodes
  // **********************************************************
  localparam logic [7:0] OP_WRITE_ANY_REGISTER_CMD = 8'h71;
  localparam logic [7:0] OP_READ_ANY_REGISTER_CMD = 8'h65;
  localparam logic [7:0] OP_RDCFG1 = 8'h35;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DIOR = 8'hBB;
  localparam logic [7:0] OP_QOR = 8'h6B;
  localparam logic [7:0] OP_SSRD = 8'h4B;

  // **********************************************************
  // Lane widths, counts and reset values
  // **********************************************************
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  // Idle levels of {io3, io2, io1, io0, cs_n, sck} after reset.
  localparam logic [5:0] PIN_IDLE = 6'h22;

  typedef enum logic [2:0]
  {
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA_IN,
    ST_DATA_OUT,
    ST_IGNORE
  } rlwc_state_t;

endpackage

// ### logic/rlwc_sync.sv
`timescale 1ns/1ps
module rlwc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic i_mclk,          // System clock.
  input wire logic i_srst,          // Synchronous reset.
  input wire logic [W-1:0] i_async, // Pins from outside.
  output logic [W-1:0] o_sync       // Second stage.
);

  logic [W-1:0] meta;

  // Two stages; only the second stage is visible to the block.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      meta <= INIT;
      o_sync <= INIT;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// ### logic/rlwc_rx.sv
`timescale 1ns/1ps
module rlwc_rx
(
  input wire logic i_mclk,        // System clock.
  input wire logic i_srst,        // Synchronous reset.
  input wire logic i_clear,       // Restart byte framing.
  input wire logic i_strobe,      // Sample point, one cycle.
  input wire logic [2:0] i_width, // Lanes per sample: 1, 2 or 4.
  input wire logic [3:0] i_io,    // Synchronised data lines.
  output logic [7:0] o_byte,      // Last complete byte.
  output logic o_done             // Byte complete pulse.
);

  logic [7:0] shift;
  logic [2:0] count;
  logic [7:0] next_shift;
  logic [2:0] next_count;

  // Bits arrive most significant first, the highest lane leading.
  assign next_shift = (i_width == rlwc_pkg::LANES_4) ?
                      {shift[3:0], i_io} :
                      (i_width == rlwc_pkg::LANES_2) ?
                      {shift[5:0], i_io[1:0]} : {shift[6:0], i_io[0]};
  assign next_count = 3'(count + i_width);

  // The bit counter wraps at eight, so bytes follow back to back.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst || i_clear)
    begin
      shift <= 8'h00;
      count <= 3'h0;
      o_done <= 1'b0;
      o_byte <= 8'h00;
    end
    else
    begin
      o_done <= i_strobe && (next_count == 3'h0);
      if (i_strobe)
      begin
        shift <= next_shift;
        count <= next_count;
        if (next_count == 3'h0)
          o_byte <= next_shift;
      end
    end
  end

endmodule

// ### logic/rlwc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Written by generic write; read by two commands.
// - Address 0x000002 writes the non-volatile copy.
// - Address 0x070002 writes the volatile copy only.
// - Generic read answers at either address.
// - Latency code in bits 7:4, default zero.
// - Code is plain binary count of cycles.
// - Latency applies to memory and sector reads.
// - Each dummy cycle is one whole clock.
// - Dummy cycles sit between address and data.
// - Bit 1 selects four-line data width.
// - Bits 3, 2 and 0 read zero.
// - Both copies exist and are writable; only the volatile one is readable.
// - Two-line protocol carries everything on two lines.
// - Dual I/O: command single, rest on two.
// - Quad data: command, address single; data four.
// - Mode byte cycles count inside the latency.
// - Hardware reset copies non-volatile into volatile.
// - Every configuration read returns the volatile copy.
// - Non-volatile write updates both copies.
// - Quad width turns protect, reset pins into data.
module rlwc_top
(
  input wire logic i_mclk,          // System clock, 25 MHz.
  input wire logic i_srst,          // Synchronous reset, high.
  input wire logic i_sck,           // Serial clock pin.
  input wire logic i_cs_n,          // Chip select pin, low.
  input wire logic [3:0] i_io,      // Data pins; 2 is protect, 3 reset.
  input wire logic i_two_line,      // Two-line protocol selected.
  input wire logic i_write_allowed, // Register writes enabled.
  input wire logic [7:0] i_rd_data, // Array byte at o_rd_addr.
  output logic [3:0] o_io,          // Data pin drive values.
  output logic [3:0] o_io_oe,       // Data pin enables, high drives.
  output logic o_wp,                // Write protect level seen.
  output logic o_hw_reset,          // Hardware reset pin active.
  output logic [23:0] o_rd_addr,    // Array read address.
  output logic o_rd_special,        // Read targets the special sector.
  output logic [3:0] o_latency,     // Active dummy cycle count.
  output logic o_quad               // Active quad width bit.
);

  // **********************************************************
  // Helpers
  // **********************************************************
  function automatic logic is_mem_rd(input logic [7:0] op);
    return op == rlwc_pkg::OP_READ || op == rlwc_pkg::OP_FAST ||
           op == rlwc_pkg::OP_DIOR || op == rlwc_pkg::OP_QOR ||
           op == rlwc_pkg::OP_SSRD;
  endfunction

  function automatic logic [2:0] addr_lanes(input logic [7:0] op,
                                            input logic two);
    return (two || op == rlwc_pkg::OP_DIOR) ?
           rlwc_pkg::LANES_2 : rlwc_pkg::LANES_1;
  endfunction

  function automatic logic [2:0] data_lanes(input logic [7:0] op,
                                            input logic two);
    return (op == rlwc_pkg::OP_QOR && !two) ?
           rlwc_pkg::LANES_4 : addr_lanes(op, two);
  endfunction

  // **********************************************************
  // Pin synchronisers and edge detection
  // **********************************************************
  logic [5:0] pins;
  logic sck_d;
  logic cs_d;

  rlwc_sync #(.W(6), .INIT(rlwc_pkg::PIN_IDLE)) u_sync
  (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_async({i_io, i_cs_n, i_sck}),
    .o_sync(pins)
  );

  // Serial clock is at most an eighth of ours, so edges are clean.
  wire sck_rise = pins[0] && !sck_d;
  wire sck_fall = !pins[0] && sck_d;
  wire active = !pins[1];
  wire cs_end = pins[1] && !cs_d;
  wire [3:0] io_s = pins[5:2];

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      sck_d <= pins[0];
      cs_d <= pins[1];
    end
  end

  // **********************************************************
  // Configuration copies
  // **********************************************************
  logic [7:0] cfg_nv;
  logic [7:0] cfg_v;
  logic [7:0] wdata;
  logic wr_pend;
  logic [23:0] addr;
  logic [7:0] opcode;

  wire [3:0] lat = cfg_v[rlwc_pkg::LAT_POS +: rlwc_pkg::LAT_W];
  wire [3:0] lat_m1 = 4'(lat - 4'h1);
  wire quad = cfg_v[rlwc_pkg::QUAD_POS];
  wire hw_rst = !quad && !io_s[3];
  wire hit_nv = addr == rlwc_pkg::REG_NV_ADDR;
  wire hit_v = addr == rlwc_pkg::REG_V_ADDR;
  wire commit = cs_end && wr_pend && i_write_allowed;
  wire [7:0] wr_val = wdata & rlwc_pkg::CFG_WR_MASK;

  assign o_wp = quad ? 1'b1 : io_s[2];
  assign o_hw_reset = hw_rst;
  assign o_latency = lat;
  assign o_quad = quad;

  // Factory value after power-up; flops stand in for the array cells.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      cfg_nv <= rlwc_pkg::CFG_RESET;
      cfg_v <= rlwc_pkg::CFG_RESET;
    end
    else
    begin
      if (commit && hit_nv)
        cfg_nv <= wr_val;
      if (hw_rst)
        cfg_v <= cfg_nv;
      else if (commit && (hit_nv || hit_v))
        cfg_v <= wr_val;
    end
  end

  // **********************************************************
  // Command sequencer
  // **********************************************************
  rlwc_pkg::rlwc_state_t state;
  rlwc_pkg::rlwc_state_t next_state;
  rlwc_pkg::rlwc_state_t cmd_next;
  rlwc_pkg::rlwc_state_t addr_next;
  logic [1:0] byte_idx;
  logic [3:0] dummy_cnt;
  logic [7:0] rx_byte;
  logic rx_done;

  wire [2:0] rx_width = (state == rlwc_pkg::ST_CMD) ?
                        (i_two_line ? rlwc_pkg::LANES_2 : rlwc_pkg::LANES_1) :
                        addr_lanes(opcode, i_two_line);
  wire rx_strobe = sck_rise && (state == rlwc_pkg::ST_CMD ||
                   state == rlwc_pkg::ST_ADDR ||
                   state == rlwc_pkg::ST_DATA_IN);

  rlwc_rx u_rx
  (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_clear(!active || hw_rst),
    .i_strobe(rx_strobe),
    .i_width(rx_width),
    .i_io(io_s),
    .o_byte(rx_byte),
    .o_done(rx_done)
  );

  // accepted commands
  // Quad data reads are refused while the width bit is clear.
  assign cmd_next = (rx_byte == rlwc_pkg::OP_RDCFG1) ?
                    rlwc_pkg::ST_DATA_OUT :
                    (rx_byte == rlwc_pkg::OP_WRITE_ANY_REGISTER_CMD ||
                     rx_byte == rlwc_pkg::OP_READ_ANY_REGISTER_CMD ||
                     (is_mem_rd(rx_byte) &&
                      (rx_byte != rlwc_pkg::OP_QOR || quad))) ?
                    rlwc_pkg::ST_ADDR : rlwc_pkg::ST_IGNORE;
  assign addr_next = (opcode == rlwc_pkg::OP_WRITE_ANY_REGISTER_CMD) ?
                     rlwc_pkg::ST_DATA_IN :
                     (opcode == rlwc_pkg::OP_READ_ANY_REGISTER_CMD || lat == 4'h0) ?
                     rlwc_pkg::ST_DATA_OUT : rlwc_pkg::ST_DUMMY;

  always_comb
  begin
    next_state = state;
    if (!active || hw_rst)
      next_state = rlwc_pkg::ST_CMD;
    else
      case (state)
        rlwc_pkg::ST_CMD:
          if (rx_done)
            next_state = cmd_next;
        rlwc_pkg::ST_ADDR:
          if (rx_done && byte_idx == rlwc_pkg::ADDR_LAST)
            next_state = addr_next;
        rlwc_pkg::ST_DUMMY:
          if (sck_rise && dummy_cnt == lat_m1)
            next_state = rlwc_pkg::ST_DATA_OUT;
        rlwc_pkg::ST_DATA_IN:
          if (rx_done)
            next_state = rlwc_pkg::ST_IGNORE;
        default:
          next_state = state;
      endcase
  end

  // Address and write data collection.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      state <= rlwc_pkg::ST_CMD;
      opcode <= 8'h00;
      addr <= 24'h000000;
      byte_idx <= 2'h0;
      dummy_cnt <= 4'h0;
      wdata <= 8'h00;
      wr_pend <= 1'b0;
      o_rd_special <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (!active)
      begin
        byte_idx <= 2'h0;
        dummy_cnt <= 4'h0;
        wr_pend <= 1'b0;
      end
      if (state == rlwc_pkg::ST_CMD && rx_done)
      begin
        opcode <= rx_byte;
        o_rd_special <= rx_byte == rlwc_pkg::OP_SSRD;
      end
      if (state == rlwc_pkg::ST_ADDR && rx_done)
      begin
        addr <= {addr[15:0], rx_byte};
        byte_idx <= 2'(byte_idx + 2'h1);
      end
      if (state == rlwc_pkg::ST_DUMMY && sck_rise)
        dummy_cnt <= 4'(dummy_cnt + 4'h1);
      if (state == rlwc_pkg::ST_DATA_IN && rx_done)
      begin
        wdata <= rx_byte;
        wr_pend <= 1'b1;
      end
    end
  end

  // **********************************************************
  // Data output
  // **********************************************************
  logic [7:0] tx_shift;
  logic [2:0] tx_cnt;
  logic [23:0] rd_addr;

  wire [2:0] out_w = data_lanes(opcode, i_two_line);
  wire [7:0] reg_val = (opcode == rlwc_pkg::OP_RDCFG1 || hit_nv || hit_v)
                       ? (cfg_v & rlwc_pkg::CFG_WR_MASK) : 8'h00;
  wire [7:0] src_byte = is_mem_rd(opcode) ? i_rd_data : reg_val;
  wire tx_load = tx_cnt == 3'h0;
  wire tx_step = sck_fall && state == rlwc_pkg::ST_DATA_OUT;
  wire [7:0] next_tx = tx_load ? src_byte : 8'(tx_shift << out_w);
  wire [2:0] tx_groups = (out_w == rlwc_pkg::LANES_4) ? 3'h1 :
                         (out_w == rlwc_pkg::LANES_2) ? 3'h3 : 3'h7;
  wire [3:0] next_io = (out_w == rlwc_pkg::LANES_4) ? next_tx[7:4] :
                       (out_w == rlwc_pkg::LANES_2) ?
                       {2'h0, next_tx[7:6]} : {2'h0, next_tx[7], 1'b0};
  wire [3:0] next_oe = (out_w == rlwc_pkg::LANES_4) ? 4'hF :
                       (out_w == rlwc_pkg::LANES_2) ? 4'h3 : 4'h2;

  assign o_rd_addr = rd_addr;

  // data after dummy
  // Pins change on the falling edge so the host samples on rising.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst || !active || hw_rst)
    begin
      tx_shift <= 8'h00;
      tx_cnt <= 3'h0;
      o_io <= 4'h0;
      o_io_oe <= 4'h0;
    end
    else if (tx_step)
    begin
      tx_shift <= next_tx;
      tx_cnt <= tx_load ? tx_groups : 3'(tx_cnt - 3'h1);
      o_io <= next_io;
      o_io_oe <= next_oe;
    end
  end

  // Array address follows each loaded byte.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      rd_addr <= 24'h000000;
    else if (state == rlwc_pkg::ST_ADDR && rx_done)
      rd_addr <= {addr[15:0], rx_byte};
    else if (tx_step && tx_load && is_mem_rd(opcode))
      rd_addr <= 24'(rd_addr + 24'h000001);
  end

  // **********************************************************
  // Checks
  // **********************************************************
  logic [4:0] rise_cnt;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst || state == rlwc_pkg::ST_ADDR)
      rise_cnt <= 5'h00;
    else if (state == rlwc_pkg::ST_DUMMY && sck_rise)
      rise_cnt <= 5'(rise_cnt + 5'h01);
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  lat_len_a: assert property ($rose(state == rlwc_pkg::ST_DATA_OUT) && is_mem_rd(opcode) |-> rise_cnt == {1'b0, lat}) else $error("dummy count differs from code");
  no_early_a: assert property (o_io_oe != 4'h0 |-> state == rlwc_pkg::ST_DATA_OUT || $past(state) == rlwc_pkg::ST_DATA_OUT) else $error("pins driven outside data");
  rsvd_zero_a: assert property ((cfg_v & ~rlwc_pkg::CFG_WR_MASK) == 8'h00 && (cfg_nv & ~rlwc_pkg::CFG_WR_MASK) == 8'h00) else $error("reserved bit set");
  nv_both_a: assert property (commit && hit_nv && !hw_rst |=> cfg_v == cfg_nv && cfg_nv == $past(wr_val)) else $error("non-volatile write missed a copy");
  v_only_a: assert property (commit && hit_v |=> $stable(cfg_nv)) else $error("volatile write touched stored copy");
  hw_copy_a: assert property (hw_rst |=> cfg_v == $past(cfg_nv)) else $error("reset did not reload");
  quad_pins_a: assert property (o_io_oe[3:2] != 2'h0 |-> quad) else $error("upper pins driven without quad");
  cfg_hold_a: assert property (active && !hw_rst |=> $stable(cfg_v)) else $error("setting changed mid command");
  rd_val_a: assert property (tx_step && tx_load && !is_mem_rd(opcode) && (opcode == rlwc_pkg::OP_RDCFG1 || hit_v) |=> tx_shift == cfg_v) else $error("read did not return volatile copy");

  nv_wr_c: cover property (commit && hit_nv);
  v_wr_c: cover property (commit && hit_v);
  lat_rd_c: cover property ($rose(state == rlwc_pkg::ST_DATA_OUT) && is_mem_rd(opcode) && lat != 4'h0);
  quad_rd_c: cover property (o_io_oe == 4'hF);

endmodule

// ### test/rlwc_host.sv
`timescale 1ns/1ps
// ******************************************
// Host serial controller model
// ******************************************
module rlwc_host
(
  input wire logic i_mclk,     // System clock.
  input wire logic [3:0] i_io, // Resolved pin levels.
  output logic o_sck,          // Serial clock, idles low.
  output logic o_cs_n,         // Chip select, active low.
  output logic [3:0] o_io,     // Pin drive values.
  output logic [3:0] o_io_oe   // Pin enables, high drives.
);
  // Start deselected with the clock still and every line released.
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
    o_io_oe = 4'h0;
  end

  // one full period
  // Five cycles low and three high, so the device has settled its
  // output well before the rise at which it is sampled.
  task automatic cyc(input logic [3:0] d, input logic [3:0] oe,
    output logic [3:0] q);
    @(posedge i_mclk);
    o_sck <= 1'b0;
    o_io <= d;
    o_io_oe <= oe;
    repeat (5) @(posedge i_mclk);
    q = i_io;
    o_sck <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask

  // Select the device a few cycles before the first clock.
  task automatic open_frame();
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask

  // Release the lines, then deselect and leave time for the commit.
  task automatic close_frame();
    @(posedge i_mclk);
    o_sck <= 1'b0;
    o_io_oe <= 4'h0;
    repeat (3) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    repeat (8) @(posedge i_mclk);
  endtask

  // lane packing
  // Most significant bits first; a single lane is read back on line 1.
  task automatic xbyte(input logic [7:0] b, input int ln,
    input logic drv, output logic [7:0] r);
    logic [7:0] sh;
    logic [3:0] m;
    logic [3:0] q;
    sh = b;
    r = 8'h00;
    m = (ln == 1) ? 4'h1 : (ln == 2) ? 4'h3 : 4'hF;
    for (int i = 0; i < 8 / ln; i++)
    begin
      cyc(4'(sh >> (8 - ln)), drv ? m : 4'h0, q);
      sh = sh << ln;
      r = (r << ln) | ((ln == 1) ? {7'h00, q[1]} : {4'h0, q & m});
    end
  endtask

  // fixed dummy count
  // The count is the programmed code whatever the clock rate, since a
  // latency that holds at a faster clock also holds at a slower one.
  // Mode cycles are part of this count, so nothing is added on top.
  task automatic dummy(input int n);
    logic [3:0] q;
    repeat (n) cyc(4'h0, 4'h0, q);
  endtask

  // Pull the reset and protect lines low for a while between frames.
  task automatic pulse_reset();
    @(posedge i_mclk);
    o_io <= 4'h0;
    o_io_oe <= 4'hC;
    repeat (8) @(posedge i_mclk);
    o_io_oe <= 4'h0;
    repeat (8) @(posedge i_mclk);
  endtask
endmodule

// ### test/tb_read_latency_width_config.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
// ******************************************
// Configuration register bench
// ******************************************
module tb_read_latency_width_config;
  logic mclk;
  logic srst;
  logic two_line;
  logic wr_ok;
  logic h_sck;
  logic h_cs_n;
  logic [3:0] pin;
  logic [3:0] h_io;
  logic [3:0] h_oe;
  logic [3:0] d_io;
  logic [3:0] d_oe;
  logic [23:0] rd_addr;
  logic rd_special;
  logic wp;
  logic hw_reset;
  logic quad;
  logic [3:0] latency;
  logic [7:0] r;
  int fail_count;
  int checks;
  int cycles;
  int cl;

  // Released lines float up to their pull-ups.
  assign pin = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe);

  // Clock at 25 MHz.
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  rlwc_top DUT (
    .i_mclk(mclk), .i_srst(srst), .i_sck(h_sck), .i_cs_n(h_cs_n),
    .i_io(pin), .i_two_line(two_line), .i_write_allowed(wr_ok),
    .i_rd_data(rd_addr[7:0] ^ 8'h5A), .o_io(d_io), .o_io_oe(d_oe),
    .o_wp(wp), .o_hw_reset(hw_reset), .o_rd_addr(rd_addr),
    .o_rd_special(rd_special), .o_latency(latency), .o_quad(quad));

  rlwc_host host (
    .i_mclk(mclk), .i_io(pin), .o_sck(h_sck), .o_cs_n(h_cs_n),
    .o_io(h_io), .o_io_oe(h_oe));

  // Array bytes the bench expects for two addresses in a row.
  function automatic logic [15:0] exp2(input logic [23:0] a);
    exp2 = {a[7:0] ^ 8'h5A, (a[7:0] + 8'h01) ^ 8'h5A};
  endfunction

  // Opcode, then the address on the wider of the two lane counts.
  task automatic start(input logic [7:0] op, input int al,
    input logic [23:0] a, input logic ha);
    host.open_frame();
    host.xbyte(op, cl, 1'b1, r);
    for (int i = 0; i < 3; i++)
      if (ha) host.xbyte(a[23 - 8 * i -: 8], (cl > al) ? cl : al, 1'b1, r);
  endtask

  // Register writes only ever go through the generic write.
  task automatic wr(input logic [23:0] a, input logic [7:0] v);
    start(rlwc_pkg::OP_WRITE_ANY_REGISTER_CMD, 1, a, 1'b1);
    host.xbyte(v, cl, 1'b1, r);
    host.close_frame();
  endtask

  task automatic rdcfg(output logic [7:0] b);
    start(rlwc_pkg::OP_RDCFG1, 1, 24'h0, 1'b0);
    host.xbyte(8'h00, cl, 1'b0, b);
    host.close_frame();
  endtask

  task automatic read_any_register_cmd(input logic [23:0] a, output logic [7:0] b);
    start(rlwc_pkg::OP_READ_ANY_REGISTER_CMD, 1, a, 1'b1);
    host.xbyte(8'h00, cl, 1'b0, b);
    host.close_frame();
  endtask

  task automatic rmem(input logic [7:0] op, input int al, input int dl,
    input logic [23:0] a, input int lat, output logic [15:0] d);
    start(op, al, a, 1'b1);
    host.dummy(lat);
    host.xbyte(8'h00, dl, 1'b0, d[15:8]);
    host.xbyte(8'h00, dl, 1'b0, d[7:0]);
    host.close_frame();
  endtask

  // Pulse the reset pin and look at the reset and protect levels seen.
  // The expected pair is {reset seen, protect seen}.
  task automatic pulse(input logic [1:0] e);
    fork
      host.pulse_reset();
      begin
        repeat (6) @(posedge mclk);
        `CHK({hw_reset, wp}, e)
      end
    join
  endtask

  task automatic t_defaults();
    logic [7:0] b;
    `CHK(latency, 4'h0)
    `CHK(quad, 1'b0)
    rdcfg(b);
    `CHK(b, rlwc_pkg::CFG_RESET)
  endtask

  task automatic t_volatile();
    logic [7:0] b;
    wr(rlwc_pkg::REG_V_ADDR, 8'hFD);
    rdcfg(b);
    `CHK(b, 8'hF0)
    `CHK(latency, 4'hF)
    read_any_register_cmd(rlwc_pkg::REG_NV_ADDR, b);
    `CHK(b, 8'hF0)
    pulse(2'b10);
    read_any_register_cmd(rlwc_pkg::REG_V_ADDR, b);
    `CHK(b, 8'h00)
  endtask

  task automatic t_nonvol();
    logic [7:0] b;
    wr(rlwc_pkg::REG_NV_ADDR, 8'h60);
    read_any_register_cmd(rlwc_pkg::REG_NV_ADDR, b);
    `CHK(b, 8'h60)
    `CHK(latency, 4'h6)
    wr(rlwc_pkg::REG_V_ADDR, 8'h00);
    rdcfg(b);
    `CHK(b, 8'h00)
    `CHK(latency, 4'h0)
    pulse(2'b10);
    rdcfg(b);
    `CHK(b, 8'h60)
  endtask

  task automatic t_refuse();
    logic [7:0] b;
    @(posedge mclk) wr_ok <= 1'b0;
    wr(rlwc_pkg::REG_NV_ADDR, 8'h30);
    rdcfg(b);
    `CHK(b, 8'h60)
    @(posedge mclk) wr_ok <= 1'b1;
    wr(24'h000003, 8'h30);
    rdcfg(b);
    `CHK(b, 8'h60)
    read_any_register_cmd(24'h000003, b);
    `CHK(b, 8'h00)
  endtask

  // Each opcode gets its own tuned latency, from none to the maximum.
  task automatic t_latency();
    logic [15:0] d;
    logic [7:0] b;
    logic [7:0] op [5];
    int lat [5] = '{0, 6, 15, 3, 1};
    int al [5] = '{1, 1, 1, 2, 1};
    int dl [5] = '{1, 1, 1, 2, 4};
    op = '{rlwc_pkg::OP_READ, rlwc_pkg::OP_FAST, rlwc_pkg::OP_SSRD,
      rlwc_pkg::OP_DIOR, rlwc_pkg::OP_QOR};
    for (int i = 0; i < 5; i++)
    begin
      wr(rlwc_pkg::REG_V_ADDR, {4'(lat[i]), 2'b00, dl[i] == 4, 1'b0});
      `CHK(latency, 4'(lat[i]))
      `CHK(quad, 1'(dl[i] == 4))
      rmem(op[i], al[i], dl[i], 24'h012340 + 24'(i), lat[i], d);
      `CHK(d, exp2(24'h012340 + 24'(i)))
      `CHK(rd_special, 1'(op[i] == rlwc_pkg::OP_SSRD))
    end
    pulse(2'b01);
    rdcfg(b);
    `CHK(b, 8'h12)
  endtask

  // With the quad bit clear the device must leave the lines alone.
  task automatic t_quad_refused();
    logic [15:0] d;
    wr(rlwc_pkg::REG_V_ADDR, 8'h20);
    rmem(rlwc_pkg::OP_QOR, 1, 4, 24'h000077, 2, d);
    `CHK(d, 16'hFFFF)
  endtask

  task automatic t_two_line();
    logic [15:0] d;
    logic [7:0] b;
    @(posedge mclk) two_line <= 1'b1;
    cl = 2;
    wr(rlwc_pkg::REG_V_ADDR, 8'h40);
    rdcfg(b);
    `CHK(b, 8'h40)
    rmem(rlwc_pkg::OP_FAST, 2, 2, 24'h00ABC0, 4, d);
    `CHK(d, exp2(24'h00ABC0))
    @(posedge mclk) two_line <= 1'b0;
    cl = 1;
  endtask

  task automatic summarize();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A hang is cut short well past the expected length of the run.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      summarize();
    end
  end

  initial
  begin
    srst = 1'b1;
    two_line = 1'b0;
    wr_ok = 1'b1;
    cl = 1;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_defaults();
    t_volatile();
    t_nonvol();
    t_refuse();
    t_latency();
    t_quad_refused();
    t_two_line();
    summarize();
  end
endmodule
